/* common/roc_pkg.sv */
// What this block does
// [RULE_01] Swing field 00=350, 01 and 10=650, 11=850 mVpp.
// [RULE_02] Register A select bit 7 set: bandwidth from its bits 3:0.
// [RULE_03] Register A in use with select clear: default 2.4 GHz.
// [RULE_04] Register A applies only while both rate pins are 0.
// [RULE_05] Register B select bit 7 set: bandwidth from its bits 3:0.
// [RULE_06] Register B in use with select clear: default 7.6 GHz.
// [RULE_07] Register B applies only with high pin 0, low pin 1.
// [RULE_08] Emphasis codes 0,1,3,4,5,7,c,d,f map to 0..8 dB.
// [RULE_09] Both pins 1 use C; high 1, low 0 (or open) use D.
// [RULE_10] Read-only 4-bit field reports the bandwidth actually selected.
// [RULE_11] Rate registers reset with select clear, so defaults apply.
package roc_pkg;

  // Register addresses on the register port
  localparam logic [7:0] ADDR_CTRL = 8'h03;
  localparam logic [7:0] ADDR_RATE_A = 8'h04;
  localparam logic [7:0] ADDR_RATE_B = 8'h05;
  localparam logic [7:0] ADDR_RATE_C = 8'h06;
  localparam logic [7:0] ADDR_RATE_D = 8'h07;
  localparam logic [7:0] ADDR_SEL_RATE = 8'h0e;

  // Field positions
  localparam int OVR_BIT = 7;
  localparam int CODE_MSB = 3;
  localparam int SWING_MSB = 5;
  localparam int SWING_LSB = 4;
  localparam int EMPH_MSB = 3;

  // Reset values
  localparam logic [7:0] RATE_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] RDATA_RST = 8'h00;

  // Default filter bandwidths in MHz, and the code reported for each
  localparam int BW_DFLT_A_MHZ = 2400;
  localparam int BW_DFLT_B_MHZ = 7600;
  localparam int BW_DFLT_C_MHZ = 8400;
  localparam int BW_DFLT_D_MHZ = 9000;
  localparam logic [3:0] DFLT_CODE_A = 4'h0;
  localparam logic [3:0] DFLT_CODE_B = 4'h0;
  localparam logic [3:0] DFLT_CODE_C = 4'h0;
  localparam logic [3:0] DFLT_CODE_D = 4'h0;

  // Which rate register is in charge
  typedef enum logic [3:0] {
    ROC_SRC_A = 4'b0001,
    ROC_SRC_B = 4'b0010,
    ROC_SRC_C = 4'b0100,
    ROC_SRC_D = 4'b1000
  } roc_src_e;

  // Output swing level
  typedef enum logic [2:0] {
    ROC_SW_350 = 3'b001,
    ROC_SW_650 = 3'b010,
    ROC_SW_850 = 3'b100
  } roc_swing_e;

  // Selected bandwidth setting
  typedef struct packed {
    roc_src_e src;
    logic dflt;
    logic [3:0] code;
  } roc_bw_s;

  // Rate pins, high then low
  typedef struct packed {
    logic speed_pin_high;
    logic speed_pin_low;
  } roc_pins_s;

  localparam roc_bw_s BW_RST = '{src: ROC_SRC_A, dflt: 1'b1,
                                 code: DFLT_CODE_A};

endpackage

/* hdl/roc_rate_pick.sv */
`timescale 1ns/1ps
module roc_rate_pick (
  // Synchronised rate pins
  input wire roc_pkg::roc_pins_s pins,
  // Rate registers A..D
  input wire logic [7:0] rate_a,
  input wire logic [7:0] rate_b,
  input wire logic [7:0] rate_c,
  input wire logic [7:0] rate_d,
  // Chosen setting
  output roc_pkg::roc_bw_s bw
);

  // Override bit set takes the code, else the register's default
  function automatic roc_pkg::roc_bw_s take(input roc_pkg::roc_src_e s,
                                           input logic [7:0] r,
                                           input logic [3:0] dc);
    roc_pkg::roc_bw_s b;
    b.src = s;
    b.dflt = ~r[roc_pkg::OVR_BIT];
    b.code = r[roc_pkg::OVR_BIT] ? r[roc_pkg::CODE_MSB:0] : dc;
    return b;
  endfunction

  // Pin decode; open pins read as high 1, low 0 through the pad pulls
  always_comb begin
    case ({pins.speed_pin_high, pins.speed_pin_low})
      2'b00: bw = take(roc_pkg::ROC_SRC_A, rate_a,
                       roc_pkg::DFLT_CODE_A); // [RULE_02] [RULE_03] [RULE_04]
      2'b01: bw = take(roc_pkg::ROC_SRC_B, rate_b,
                       roc_pkg::DFLT_CODE_B); // [RULE_05] [RULE_06] [RULE_07]
      2'b11: bw = take(roc_pkg::ROC_SRC_C, rate_c,
                       roc_pkg::DFLT_CODE_C); // [RULE_09]
      default: bw = take(roc_pkg::ROC_SRC_D, rate_d,
                         roc_pkg::DFLT_CODE_D); // [RULE_09]
    endcase
  end

endmodule

/* hdl/roc_cfg_decode.sv */
`timescale 1ns/1ps
module roc_cfg_decode (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Rate pins, asynchronous
  input wire logic speed_pin_high,
  input wire logic speed_pin_low,
  // Register port behind the serial decoder
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_q,
  // Analog settings
  output roc_pkg::roc_swing_e swing_q,
  output logic [3:0] emph_db_q,
  output logic emph_bad_q,
  output roc_pkg::roc_bw_s bw_q
);

  logic [7:0] rate_a_q, rate_b_q, rate_c_q, rate_d_q, ctrl_q;
  logic [7:0] rate_a_d, rate_b_d, rate_c_d, rate_d_d, ctrl_d;
  logic [7:0] reg_rdata_d;
  roc_pkg::roc_pins_s pin_s1_q, pin_s2_q;
  roc_pkg::roc_bw_s bw_d;
  roc_pkg::roc_swing_e swing_d;
  logic [3:0] emph_db_d;
  logic emph_bad_d;

  // Emphasis code to dB; unlisted codes fall back to 0 dB and flag
  function automatic logic [4:0] emph_map(input logic [3:0] c);
    case (c)
      4'h0: emph_map = 5'h00; // [RULE_08]
      4'h1: emph_map = 5'h01;
      4'h3: emph_map = 5'h02;
      4'h4: emph_map = 5'h03;
      4'h5: emph_map = 5'h04;
      4'h7: emph_map = 5'h05;
      4'hc: emph_map = 5'h06;
      4'hd: emph_map = 5'h07;
      4'hf: emph_map = 5'h08;
      default: emph_map = 5'h10;
    endcase
  endfunction

  // Two stages before anything looks at the pins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      pin_s1_q <= '{speed_pin_high: speed_pin_high,
                    speed_pin_low: speed_pin_low};
      pin_s2_q <= pin_s1_q;
    end
  end

  // Register writes and read mux
  always_comb begin
    rate_a_d = rate_a_q;
    rate_b_d = rate_b_q;
    rate_c_d = rate_c_q;
    rate_d_d = rate_d_q;
    ctrl_d = ctrl_q;
    if (reg_wr_en) begin
      case (reg_addr)
        roc_pkg::ADDR_CTRL: ctrl_d = reg_wdata;
        roc_pkg::ADDR_RATE_A: rate_a_d = reg_wdata;
        roc_pkg::ADDR_RATE_B: rate_b_d = reg_wdata;
        roc_pkg::ADDR_RATE_C: rate_c_d = reg_wdata;
        roc_pkg::ADDR_RATE_D: rate_d_d = reg_wdata;
        default: ctrl_d = ctrl_q;
      endcase
    end
    reg_rdata_d = reg_rdata_q;
    if (reg_rd_en) begin
      case (reg_addr)
        roc_pkg::ADDR_CTRL: reg_rdata_d = ctrl_q;
        roc_pkg::ADDR_RATE_A: reg_rdata_d = rate_a_q;
        roc_pkg::ADDR_RATE_B: reg_rdata_d = rate_b_q;
        roc_pkg::ADDR_RATE_C: reg_rdata_d = rate_c_q;
        roc_pkg::ADDR_RATE_D: reg_rdata_d = rate_d_q;
        roc_pkg::ADDR_SEL_RATE:
          reg_rdata_d = {4'h0, bw_q.code}; // [RULE_10]
        default: reg_rdata_d = 8'h00;
      endcase
    end
  end

  // Select-clear reset keeps pin defaults in charge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rate_a_q <= roc_pkg::RATE_RST; // [RULE_11]
      rate_b_q <= roc_pkg::RATE_RST;
      rate_c_q <= roc_pkg::RATE_RST;
      rate_d_q <= roc_pkg::RATE_RST;
      ctrl_q <= roc_pkg::CTRL_RST;
      reg_rdata_q <= roc_pkg::RDATA_RST;
    end else begin
      rate_a_q <= rate_a_d;
      rate_b_q <= rate_b_d;
      rate_c_q <= rate_c_d;
      rate_d_q <= rate_d_d;
      ctrl_q <= ctrl_d;
      reg_rdata_q <= reg_rdata_d;
    end
  end

  // Pin-driven register choice
  roc_rate_pick u_pick (
    .pins(pin_s2_q),
    .rate_a(rate_a_q),
    .rate_b(rate_b_q),
    .rate_c(rate_c_q),
    .rate_d(rate_d_q),
    .bw(bw_d)
  );

  // Swing and emphasis decode
  always_comb begin
    case (ctrl_q[roc_pkg::SWING_MSB:roc_pkg::SWING_LSB])
      2'b00: swing_d = roc_pkg::ROC_SW_350; // [RULE_01]
      2'b11: swing_d = roc_pkg::ROC_SW_850;
      default: swing_d = roc_pkg::ROC_SW_650;
    endcase
    {emph_bad_d, emph_db_d} = emph_map(ctrl_q[roc_pkg::EMPH_MSB:0]);
  end

  // Settings registered so analog controls never glitch
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      swing_q <= roc_pkg::ROC_SW_350;
      emph_db_q <= 4'h0;
      emph_bad_q <= 1'b0;
      bw_q <= roc_pkg::BW_RST;
    end else begin
      swing_q <= swing_d;
      emph_db_q <= emph_db_d;
      emph_bad_q <= emph_bad_d;
      bw_q <= bw_d;
    end
  end

  // Helper: set once a write has reached a rate register since reset
  logic wrote_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wrote_q <= 1'b0;
    end else if (reg_wr_en && reg_addr >= roc_pkg::ADDR_RATE_A
                 && reg_addr <= roc_pkg::ADDR_RATE_D) begin
      wrote_q <= 1'b1;
    end
  end

  property p_swing_decode;
    @(posedge clk) disable iff (!arst_n)
    reg_wr_en && reg_addr == roc_pkg::ADDR_CTRL && reg_wdata[5:4] == 2'b10
    |-> ##2 swing_q == roc_pkg::ROC_SW_650;
  endproperty
  a_swing_decode: assert property (p_swing_decode) // [RULE_01]
    else $error("swing decode wrong");

  property p_a_code;
    @(posedge clk) disable iff (!arst_n)
    pin_s2_q == 2'b00 && rate_a_q[7]
    |=> !bw_q.dflt && bw_q.code == $past(rate_a_q[3:0]);
  endproperty
  a_a_code: assert property (p_a_code) // [RULE_02]
    else $error("register A code not applied");

  property p_a_dflt;
    @(posedge clk) disable iff (!arst_n)
    pin_s2_q == 2'b00 && !rate_a_q[7] |=> bw_q.dflt;
  endproperty
  a_a_dflt: assert property (p_a_dflt) // [RULE_03]
    else $error("register A default not applied");

  property p_a_pins;
    @(posedge clk) disable iff (!arst_n)
    $stable(speed_pin_high) && $stable(speed_pin_low)
      && !speed_pin_high && !speed_pin_low
    ##1 (!speed_pin_high && !speed_pin_low) [*2]
    |=> bw_q.src == roc_pkg::ROC_SRC_A;
  endproperty
  a_a_pins: assert property (p_a_pins) // [RULE_04]
    else $error("pins 00 did not pick register A");

  property p_b_code;
    @(posedge clk) disable iff (!arst_n)
    pin_s2_q == 2'b01 && rate_b_q[7]
    |=> !bw_q.dflt && bw_q.code == $past(rate_b_q[3:0]);
  endproperty
  a_b_code: assert property (p_b_code) // [RULE_05]
    else $error("register B code not applied");

  property p_b_dflt;
    @(posedge clk) disable iff (!arst_n)
    pin_s2_q == 2'b01 && !rate_b_q[7]
    |=> bw_q.dflt && bw_q.code == roc_pkg::DFLT_CODE_B;
  endproperty
  a_b_dflt: assert property (p_b_dflt) // [RULE_06]
    else $error("register B default not applied");

  property p_b_pins;
    @(posedge clk) disable iff (!arst_n)
    pin_s2_q == 2'b01 |=> bw_q.src == roc_pkg::ROC_SRC_B;
  endproperty
  a_b_pins: assert property (p_b_pins) // [RULE_07]
    else $error("pins 01 did not pick register B");

  property p_emph;
    @(posedge clk) disable iff (!arst_n)
    reg_wr_en && reg_addr == roc_pkg::ADDR_CTRL && reg_wdata[3:0] == 4'hc
    |-> ##2 emph_db_q == 4'h6 && !emph_bad_q;
  endproperty
  a_emph: assert property (p_emph) // [RULE_08]
    else $error("emphasis decode wrong");

  property p_cd_pins;
    @(posedge clk) disable iff (!arst_n)
    pin_s2_q[1] |=> bw_q.src == ($past(pin_s2_q[0]) ?
      roc_pkg::ROC_SRC_C : roc_pkg::ROC_SRC_D);
  endproperty
  a_cd_pins: assert property (p_cd_pins) // [RULE_09]
    else $error("C or D selection wrong");

  property p_readback;
    @(posedge clk) disable iff (!arst_n)
    reg_rd_en && reg_addr == roc_pkg::ADDR_SEL_RATE
    |=> reg_rdata_q == {4'h0, $past(bw_q.code)};
  endproperty
  a_readback: assert property (p_readback) // [RULE_10]
    else $error("selected rate readback wrong");

  property p_reset_sel;
    @(posedge clk) disable iff (!arst_n)
    !wrote_q |-> !rate_a_q[7] && !rate_b_q[7] && !rate_c_q[7]
      && !rate_d_q[7];
  endproperty
  a_reset_sel: assert property (p_reset_sel) // [RULE_11]
    else $error("select bit set without a write");

  property p_cov_b_ovr;
    @(posedge clk) disable iff (!arst_n)
    bw_q.src == roc_pkg::ROC_SRC_B && !bw_q.dflt;
  endproperty
  c_cov_b_ovr: cover property (p_cov_b_ovr);

  property p_cov_pin_move;
    @(posedge clk) disable iff (!arst_n)
    bw_q.src == roc_pkg::ROC_SRC_A ##1 bw_q.src == roc_pkg::ROC_SRC_C;
  endproperty
  c_cov_pin_move: cover property (p_cov_pin_move);

  property p_cov_emph_bad;
    @(posedge clk) disable iff (!arst_n) emph_bad_q;
  endproperty
  c_cov_emph_bad: cover property (p_cov_emph_bad);

endmodule

/* tb/roc_host_model.sv */
`timescale 1ns/1ps
// Host side of the register port; every strobe is a one-cycle pulse
module roc_host_model (
  // Clock
  input wire logic clk,
  // Register port
  output logic reg_wr_en,
  output logic reg_rd_en,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata_q
);
  // Idle state before the first request
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  // One write; released lines are inverted so stale values never match
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk);
    #1;
    reg_wr_en = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  // One read; data is valid just after the taking edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    reg_rd_en = 1'b1;
    reg_addr = a;
    @(posedge clk);
    #1;
    reg_rd_en = 1'b0;
    reg_addr = ~a;
    d = reg_rdata_q;
  endtask
endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ps
// Self-checking bench for the configuration decode block
module tb_top;
  logic clk;
  logic arst_n;
  logic speed_pin_high;
  logic speed_pin_low;
  logic reg_wr_en;
  logic reg_rd_en;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata_q;
  roc_pkg::roc_swing_e swing_q;
  logic [3:0] emph_db_q;
  logic emph_bad_q;
  roc_pkg::roc_bw_s bw_q;
  logic [7:0] rdat;
  int err_total;
  int compares;

  roc_host_model u_host (.clk(clk), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata_q(reg_rdata_q));

  roc_cfg_decode u_dut (.clk(clk), .arst_n(arst_n),
    .speed_pin_high(speed_pin_high), .speed_pin_low(speed_pin_low),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .swing_q(swing_q),
    .emph_db_q(emph_db_q), .emph_bad_q(emph_bad_q), .bw_q(bw_q));

  // Free-running 8 ns clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Compare and count; four-state so unknowns never match
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic roc_pkg::roc_bw_s bw(input roc_pkg::roc_src_e s,
                                          input logic f,
                                          input logic [3:0] c);
    bw = '{src: s, dflt: f, code: c};
  endfunction

  // Wait fixed edges, then step off the edge
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Pins pass two sync flops, so the result lands three edges later
  task automatic pins(input logic h, input logic l);
    speed_pin_high = h;
    speed_pin_low = l;
    settle(3);
  endtask

  task automatic t_reset();
    chk(bw_q, bw(roc_pkg::ROC_SRC_A, 1'b1, roc_pkg::DFLT_CODE_A));
    chk(swing_q, roc_pkg::ROC_SW_350);
    u_host.rd(roc_pkg::ADDR_RATE_A, rdat);
    chk(rdat, 8'h00);
    u_host.rd(roc_pkg::ADDR_RATE_B, rdat);
    chk(rdat, 8'h00);
    $display("test reset done");
  endtask

  // Every emphasis code, with the swing field cycling alongside
  task automatic t_ctrl();
    logic [63:0] db_tbl;
    logic [15:0] bad_tbl;
    logic [11:0] sw_tbl;
    db_tbl = 64'h8076_0000_5043_2010;
    bad_tbl = 16'h4f44;
    sw_tbl = 12'b100_010_010_001;
    for (int i = 0; i < 16; i++) begin
      u_host.wr(roc_pkg::ADDR_CTRL, {2'b00, i[1:0], i[3:0]});
      settle(1);
      chk(emph_db_q, db_tbl[i*4 +: 4]);
      chk(emph_bad_q, bad_tbl[i]);
      chk(swing_q, sw_tbl[i[1:0]*3 +: 3]);
    end
    $display("test ctrl done");
  endtask

  task automatic t_select();
    pins(1'b0, 1'b0);
    chk(bw_q, bw(roc_pkg::ROC_SRC_A, 1'b1, roc_pkg::DFLT_CODE_A));
    u_host.wr(roc_pkg::ADDR_RATE_A, 8'h85);
    settle(1);
    chk(bw_q, bw(roc_pkg::ROC_SRC_A, 1'b0, 4'h5));
    u_host.rd(roc_pkg::ADDR_SEL_RATE, rdat);
    chk(rdat, 8'h05);
    pins(1'b0, 1'b1);
    chk(bw_q, bw(roc_pkg::ROC_SRC_B, 1'b1, roc_pkg::DFLT_CODE_B));
    u_host.wr(roc_pkg::ADDR_RATE_B, 8'h8a);
    settle(1);
    chk(bw_q, bw(roc_pkg::ROC_SRC_B, 1'b0, 4'ha));
    u_host.rd(roc_pkg::ADDR_SEL_RATE, rdat);
    chk(rdat, 8'h0a);
    u_host.wr(roc_pkg::ADDR_RATE_B, 8'h0c);
    settle(1);
    chk(bw_q, bw(roc_pkg::ROC_SRC_B, 1'b1, roc_pkg::DFLT_CODE_B));
    pins(1'b1, 1'b1);
    chk(bw_q, bw(roc_pkg::ROC_SRC_C, 1'b1, roc_pkg::DFLT_CODE_C));
    pins(1'b1, 1'b0);
    chk(bw_q, bw(roc_pkg::ROC_SRC_D, 1'b1, roc_pkg::DFLT_CODE_D));
    pins(1'b0, 1'b0);
    chk(bw_q, bw(roc_pkg::ROC_SRC_A, 1'b0, 4'h5));
    $display("test select done");
  endtask

  // Read-only place must not take writes; unmapped places must read as zero
  task automatic t_refuse();
    u_host.wr(roc_pkg::ADDR_SEL_RATE, 8'hff);
    settle(1);
    u_host.rd(roc_pkg::ADDR_SEL_RATE, rdat);
    chk(rdat, 8'h05);
    u_host.rd(roc_pkg::ADDR_RATE_B, rdat);
    chk(rdat, 8'h0c);
    u_host.rd(8'h20, rdat);
    chk(rdat, 8'h00);
    $display("test refuse done");
  endtask

  // Registers C and D, C reached by a direct jump from A, then D from C
  task automatic t_cd();
    u_host.wr(roc_pkg::ADDR_RATE_C, 8'h83);
    u_host.wr(roc_pkg::ADDR_RATE_D, 8'h8e);
    pins(1'b1, 1'b1);
    chk(bw_q, bw(roc_pkg::ROC_SRC_C, 1'b0, 4'h3));
    u_host.rd(roc_pkg::ADDR_SEL_RATE, rdat);
    chk(rdat, 8'h03);
    pins(1'b1, 1'b0);
    chk(bw_q, bw(roc_pkg::ROC_SRC_D, 1'b0, 4'he));
    u_host.rd(roc_pkg::ADDR_RATE_D, rdat);
    chk(rdat, 8'h8e);
    u_host.rd(roc_pkg::ADDR_CTRL, rdat);
    chk(rdat, 8'h3f);
    pins(1'b0, 1'b0);
    chk(bw_q, bw(roc_pkg::ROC_SRC_A, 1'b0, 4'h5));
    $display("test cd done");
  endtask

  // Mid-run reset must drop the select bits written to A and C so far
  task automatic t_rereset();
    arst_n = 1'b0;
    settle(2);
    chk(bw_q, bw(roc_pkg::ROC_SRC_A, 1'b1, roc_pkg::DFLT_CODE_A));
    chk(reg_rdata_q, roc_pkg::RDATA_RST);
    arst_n = 1'b1;
    settle(3);
    chk(bw_q, bw(roc_pkg::ROC_SRC_A, 1'b1, roc_pkg::DFLT_CODE_A));
    chk(swing_q, roc_pkg::ROC_SW_350);
    u_host.rd(roc_pkg::ADDR_RATE_C, rdat);
    chk(rdat, 8'h00);
    $display("test rereset done");
  endtask

  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Main sequence after a 16-cycle reset
  initial begin
    err_total = 0;
    compares = 0;
    arst_n = 1'b0;
    speed_pin_high = 1'b0;
    speed_pin_low = 1'b0;
    repeat (16) @(posedge clk);
    #1;
    arst_n = 1'b1;
    t_reset();
    t_ctrl();
    t_select();
    t_refuse();
    t_cd();
    t_rereset();
    close_out();
  end

  // Watchdog so a stuck run still reaches the verdict
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    $display("watchdog expired");
    close_out();
  end
endmodule
